// ### utx_pkg.sv
// Constants shared by the transmit endpoint controller and its buffer.
// Assumes a 50 MHz register clock and a 32-bit AHB-Lite register bus.
`default_nettype none
package utx_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_GUARD = 8'h04;
	localparam logic [7:0] OFS_FIFO = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	// Endpoint control field positions
	localparam int BIT_AUTO_READY = 31;
	localparam int BIT_ISO = 30;
	localparam int BIT_DIR_TX = 29;
	localparam int BIT_DMA_EN = 28;
	localparam int BIT_FORCE_TOG = 27;
	localparam int BIT_DMA_MODE = 26;
	localparam int BIT_TOG_WEN = 25;
	localparam int BIT_TOGGLE = 24;
	localparam int BIT_PKT_READY = 16;
	localparam int MAXP_W = 11;
	// Guard register field positions
	localparam int BIT_PHY_RST = 25;
	localparam int BIT_BUS_RST = 24;
	localparam int LS_LSB = 16;
	localparam int FS_LSB = 8;
	localparam int HS_LSB = 0;
	// Values after reset
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] GUARD_RESET = 32'h0072_7780;
	// Speed codes on the speed input
	localparam logic [1:0] SPD_LOW = 2'h0;
	localparam logic [1:0] SPD_FULL = 2'h1;
	localparam logic [1:0] SPD_HI = 2'h2;
	// Timing: clock period and guard steps in tenths of a nanosecond
	localparam int CLK_PERIOD_NS = 20;
	localparam int CLK_PERIOD_TNS = CLK_PERIOD_NS * 10;
	localparam int LS_STEP_TNS = 10670;
	localparam int FS_STEP_TNS = 5333;
	localparam int HS_STEP_TNS = 1333;
	// Frame and microframe lengths
	localparam int FRAME_NS = 1000000;
	localparam int UFRAME_NS = 125000;
	localparam int FRAME_CYC = FRAME_NS / CLK_PERIOD_NS;
	localparam int UFRAME_CYC = UFRAME_NS / CLK_PERIOD_NS;
	localparam int BYTES_PER_WORD = 4;
	localparam int BUF_DEPTH = 2;
endpackage
`default_nettype wire

// ### utx_buf.sv
// Two-entry buffer between the register-side writer and the link.
// Assumes the reader may hold out_ready low for any number of cycles.
`default_nettype none
module utx_buf #(
	parameter int WIDTH = 32,
	parameter int DEPTH = utx_pkg::BUF_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	// Structure is a head register plus one spare entry; refuse anything else
	if (DEPTH != 2 || WIDTH < 1) begin : g_bad_cfg
		$error("utx_buf serves only DEPTH 2 and WIDTH above 0");
	end

	logic [WIDTH-1:0] spare; // Second entry, drains into the head
	logic spare_v;
	logic push;
	logic pop;

	// Ready only while the spare is free, so a stalled reader fills both entries
	assign in_ready_o = !spare_v;
	assign push = in_valid_i && !spare_v;
	assign pop = out_valid_o && out_ready_i;

	// Head entry, presented to the link
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end else if (pop && spare_v) begin
			out_data_o <= spare;
		end else if (push && (pop || !out_valid_o)) begin
			out_valid_o <= 1'b1;
			out_data_o <= in_data_i;
		end else if (pop) begin
			out_valid_o <= 1'b0;
		end
	end

	// Spare entry, used only while the head is held
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			spare_v <= 1'b0;
			spare <= '0;
		end else if (pop && spare_v) begin
			spare_v <= 1'b0;
		end else if (push && out_valid_o && !pop) begin
			spare_v <= 1'b1;
			spare <= in_data_i;
		end
	end
endmodule
`default_nettype wire

// ### utx_ep_ctrl.sv
// Transmit endpoint control with frame-end guard timing, AHB-Lite slave.
// Assumes one 50 MHz clock, a synchronous link handshake and a sof pulse.
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`default_nettype none
module utx_ep_ctrl #(
	parameter int FRAME_CYCLES = utx_pkg::FRAME_CYC,
	parameter int UFRAME_CYCLES = utx_pkg::UFRAME_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Role and link state
	input wire logic host_mode_i,
	input wire logic [1:0] speed_i,
	input wire logic sof_i,
	input wire logic tx_done_i,
	// Packet words toward the link
	output logic [31:0] tx_data_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	// Endpoint state toward the packet engine
	output logic tx_packet_ready_o,
	output logic data_toggle_o,
	output logic iso_mode_o,
	output logic dir_tx_o,
	output logic dma_req_o,
	output logic guard_block_o,
	output logic phy_rst_o,
	output logic bus_rst_o
);
	if (FRAME_CYCLES < 2 || FRAME_CYCLES > 131071 || UFRAME_CYCLES < 2
			|| UFRAME_CYCLES > FRAME_CYCLES) begin : g_bad_frame
		$error("utx_ep_ctrl frame lengths out of range");
	end

	// Control fields
	logic auto_ready_enable;
	logic iso_sel; // Stored timed-transfer choice, masked by role
	logic dir_tx;
	logic dma_request_enable;
	logic dma_request_mode;
	logic toggle_write_enable;
	logic data_toggle_bit;
	logic tx_packet_ready;
	logic [utx_pkg::MAXP_W-1:0] tx_max_packet_size;
	logic force_pulse; // One cycle after a force-toggle write
	// Guard and soft reset fields
	logic phy_domain_reset;
	logic bus_domain_reset;
	logic [7:0] low_speed_frame_guard;
	logic [7:0] full_speed_frame_guard;
	logic [7:0] hi_speed_frame_guard;
	// Bus data phase state
	logic ph_valid;
	logic ph_write;
	logic [7:0] ph_addr;
	logic wr_en; // Register write completes this cycle
	logic fifo_push; // Word handed to the buffer
	logic buf_in_ready;
	// Packet accounting
	logic [12:0] byte_count;
	logic [12:0] next_byte_count;
	logic [16:0] frame_left;
	logic [31:0] rem_tns;
	logic [31:0] guard_tns;

	// Address phase capture; FIFO writes take at least one wait state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr <= '0;
		end else if (hready_i && hsel_i && htrans_i[1]) begin
			ph_valid <= 1'b1;
			ph_write <= hwrite_i;
			ph_addr <= haddr_i[7:0];
		end else if (hready_i || fifo_push) begin
			ph_valid <= 1'b0;
		end
	end

	// Wait states on every FIFO write, held until the buffer takes the word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hreadyout_o <= 1'b1;
		end else if (hready_i && hsel_i && htrans_i[1] && hwrite_i
				&& haddr_i[7:0] == utx_pkg::OFS_FIFO) begin
			hreadyout_o <= 1'b0;
		end else if (fifo_push) begin
			hreadyout_o <= 1'b1;
		end
	end

	// Response is always OKAY; unmapped addresses read zero, writes dropped
	always_ff @(posedge clk_i) hresp_o <= 1'b0;

	assign wr_en = ph_valid && ph_write && hreadyout_o;
	assign fifo_push = ph_valid && ph_write && !hreadyout_o
			&& ph_addr == utx_pkg::OFS_FIFO && buf_in_ready;

	// Read data prepared at the address phase edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hrdata_o <= '0;
		end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
			if (haddr_i[7:0] == utx_pkg::OFS_CTRL) begin
				hrdata_o <= '0;
				hrdata_o[utx_pkg::BIT_AUTO_READY] <= auto_ready_enable;
				hrdata_o[utx_pkg::BIT_ISO] <= iso_sel && !host_mode_i;
				hrdata_o[utx_pkg::BIT_DIR_TX] <= dir_tx;
				hrdata_o[utx_pkg::BIT_DMA_EN] <= dma_request_enable;
				hrdata_o[utx_pkg::BIT_DMA_MODE] <= dma_request_mode;
				hrdata_o[utx_pkg::BIT_TOG_WEN] <= toggle_write_enable;
				hrdata_o[utx_pkg::BIT_TOGGLE] <= data_toggle_bit;
				hrdata_o[utx_pkg::BIT_PKT_READY] <= tx_packet_ready;
				hrdata_o[utx_pkg::MAXP_W-1:0] <= tx_max_packet_size;
			end else if (haddr_i[7:0] == utx_pkg::OFS_GUARD) begin
				hrdata_o <= {6'h00, phy_domain_reset, bus_domain_reset,
						low_speed_frame_guard, full_speed_frame_guard,
						hi_speed_frame_guard};
			end else if (haddr_i[7:0] == utx_pkg::OFS_STAT) begin
				hrdata_o <= {12'h000, tx_valid_o, !buf_in_ready, guard_block_o,
						byte_count, 4'h0};
			end else begin
				hrdata_o <= '0;
			end
		end
	end

	// Endpoint configuration written by software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			auto_ready_enable <= utx_pkg::CTRL_RESET[utx_pkg::BIT_AUTO_READY];
			iso_sel <= utx_pkg::CTRL_RESET[utx_pkg::BIT_ISO];
			dir_tx <= utx_pkg::CTRL_RESET[utx_pkg::BIT_DIR_TX];
			dma_request_enable <= utx_pkg::CTRL_RESET[utx_pkg::BIT_DMA_EN];
			dma_request_mode <= utx_pkg::CTRL_RESET[utx_pkg::BIT_DMA_MODE];
			toggle_write_enable <= utx_pkg::CTRL_RESET[utx_pkg::BIT_TOG_WEN];
			tx_max_packet_size <= utx_pkg::CTRL_RESET[utx_pkg::MAXP_W-1:0];
		end else if (wr_en && ph_addr == utx_pkg::OFS_CTRL) begin
			auto_ready_enable <= hwdata_i[utx_pkg::BIT_AUTO_READY];
			// Host role leaves the stored choice untouched
			if (!host_mode_i) begin
				iso_sel <= hwdata_i[utx_pkg::BIT_ISO];
			end
			dir_tx <= hwdata_i[utx_pkg::BIT_DIR_TX];
			dma_request_enable <= hwdata_i[utx_pkg::BIT_DMA_EN];
			// Ordering of mode against enable is left to software
			dma_request_mode <= hwdata_i[utx_pkg::BIT_DMA_MODE];
			toggle_write_enable <= hwdata_i[utx_pkg::BIT_TOG_WEN];
			tx_max_packet_size <= hwdata_i[utx_pkg::MAXP_W-1:0];
		end
	end

	// Force-toggle request lives one cycle and always reads back zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			force_pulse <= 1'b0;
		end else begin
			force_pulse <= wr_en && ph_addr == utx_pkg::OFS_CTRL
					&& hwdata_i[utx_pkg::BIT_FORCE_TOG];
		end
	end

	// Data toggle: flips on a sent packet or a force, written only in host role when enabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_toggle_bit <= utx_pkg::CTRL_RESET[utx_pkg::BIT_TOGGLE];
		end else if (force_pulse || tx_done_i) begin
			data_toggle_bit <= !data_toggle_bit;
		end else if (wr_en && ph_addr == utx_pkg::OFS_CTRL && host_mode_i
				&& toggle_write_enable) begin
			data_toggle_bit <= hwdata_i[utx_pkg::BIT_TOGGLE];
		end
	end

	// Byte count of the packet being loaded, saturating at the top
	always_comb begin
		next_byte_count = byte_count;
		if (fifo_push && byte_count < 13'h1FFC) begin
			next_byte_count = byte_count + 13'(utx_pkg::BYTES_PER_WORD);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			byte_count <= '0;
		end else if (force_pulse || tx_done_i) begin
			byte_count <= '0;
		end else begin
			byte_count <= next_byte_count;
		end
	end

	// Packet ready: set by software or auto-ready, cleared by send or force.
	// A set arriving with a clear wins, so no packet is lost.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_packet_ready <= utx_pkg::CTRL_RESET[utx_pkg::BIT_PKT_READY];
		end else if (wr_en && ph_addr == utx_pkg::OFS_CTRL
				&& hwdata_i[utx_pkg::BIT_PKT_READY]) begin
			tx_packet_ready <= 1'b1;
		end else if (auto_ready_enable && fifo_push && tx_max_packet_size != '0
				&& next_byte_count >= {2'b00, tx_max_packet_size}) begin
			tx_packet_ready <= 1'b1;
		end else if (force_pulse || tx_done_i) begin
			tx_packet_ready <= 1'b0;
		end
	end

	// Guard intervals and soft resets
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phy_domain_reset <= utx_pkg::GUARD_RESET[utx_pkg::BIT_PHY_RST];
			bus_domain_reset <= utx_pkg::GUARD_RESET[utx_pkg::BIT_BUS_RST];
			low_speed_frame_guard <= utx_pkg::GUARD_RESET[utx_pkg::LS_LSB +: 8];
			full_speed_frame_guard <= utx_pkg::GUARD_RESET[utx_pkg::FS_LSB +: 8];
			hi_speed_frame_guard <= utx_pkg::GUARD_RESET[utx_pkg::HS_LSB +: 8];
		end else if (wr_en && ph_addr == utx_pkg::OFS_GUARD) begin
			phy_domain_reset <= hwdata_i[utx_pkg::BIT_PHY_RST];
			bus_domain_reset <= hwdata_i[utx_pkg::BIT_BUS_RST];
			low_speed_frame_guard <= hwdata_i[utx_pkg::LS_LSB +: 8];
			full_speed_frame_guard <= hwdata_i[utx_pkg::FS_LSB +: 8];
			hi_speed_frame_guard <= hwdata_i[utx_pkg::HS_LSB +: 8];
		end
	end

	// Domain reset outputs follow their bits for as long as they are set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phy_rst_o <= 1'b0;
			bus_rst_o <= 1'b0;
		end else begin
			phy_rst_o <= phy_domain_reset;
			bus_rst_o <= bus_domain_reset;
		end
	end

	// Time left in the frame, reloaded at each start of frame
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_left <= '0;
		end else if (sof_i) begin
			frame_left <= (speed_i == utx_pkg::SPD_HI) ? 17'(UFRAME_CYCLES - 1)
					: 17'(FRAME_CYCLES - 1);
		end else if (frame_left != '0) begin
			frame_left <= frame_left - 17'h00001;
		end
	end

	// Remaining time and guard window, both in tenths of a nanosecond
	always_comb begin
		rem_tns = 32'(frame_left) * 32'(utx_pkg::CLK_PERIOD_TNS);
		if (speed_i == utx_pkg::SPD_LOW) begin
			guard_tns = 32'(low_speed_frame_guard) * 32'(utx_pkg::LS_STEP_TNS);
		end else if (speed_i == utx_pkg::SPD_FULL) begin
			guard_tns = 32'(full_speed_frame_guard) * 32'(utx_pkg::FS_STEP_TNS);
		end else begin
			guard_tns = 32'(hi_speed_frame_guard) * 32'(utx_pkg::HS_STEP_TNS);
		end
	end

	// Block new transactions once the remainder drops below the window
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			guard_block_o <= 1'b0;
		end else begin
			guard_block_o <= rem_tns < guard_tns;
		end
	end

	// Endpoint state toward the packet engine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_packet_ready_o <= 1'b0;
			data_toggle_o <= 1'b0;
			iso_mode_o <= 1'b0;
			dir_tx_o <= 1'b0;
		end else begin
			tx_packet_ready_o <= tx_packet_ready;
			data_toggle_o <= data_toggle_bit;
			iso_mode_o <= iso_sel && !host_mode_i;
			dir_tx_o <= dir_tx;
		end
	end

	// DMA request: mode 0 asks whenever a word fits and no packet is ready, mode 1 only until full size
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dma_req_o <= 1'b0;
		end else if (!dma_request_enable) begin
			dma_req_o <= 1'b0;
		end else if (dma_request_mode) begin
			dma_req_o <= buf_in_ready && !tx_packet_ready
					&& byte_count < {2'b00, tx_max_packet_size};
		end else begin
			dma_req_o <= buf_in_ready && !tx_packet_ready;
		end
	end

	// Packet words pass the buffer so a stalled link loses nothing
	utx_buf #(
		.WIDTH(32),
		.DEPTH(utx_pkg::BUF_DEPTH)
	) u_buf (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(fifo_push),
		.in_data_i(hwdata_i),
		.in_ready_o(buf_in_ready),
		.out_valid_o(tx_valid_o),
		.out_data_o(tx_data_o),
		.out_ready_i(tx_ready_i)
	);
endmodule
`default_nettype wire

// ### utx_ep_ctrl_sva.sv
// Checker for the transmit endpoint controller, port level only.
// Assumes hready_i carries the slave's own hreadyout_o and no pipelining.
`default_nettype none
module utx_ep_ctrl_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic host_mode_i,
	input wire logic tx_done_i,
	input wire logic [31:0] tx_data_o,
	input wire logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire logic data_toggle_o,
	input wire logic iso_mode_o,
	input wire logic dir_tx_o,
	input wire logic dma_req_o,
	input wire logic phy_rst_o,
	input wire logic bus_rst_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic acc; // Address phase taken
	logic wp_q; // Write data phase open
	logic [7:0] wa_q; // Offset of that write
	logic [31:0] ctrl_sh; // Last control word written
	logic [31:0] guard_sh; // Last guard word written
	logic [2:0] quiet; // Cycles since a write landed
	logic [2:0] tog_win; // Cycles in which the toggle may move
	assign acc = hsel_i && hready_i && htrans_i[1];
	// Shadow of written words; outputs lag, so checks wait for quiet
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp_q <= 1'b0;
			wa_q <= 8'h00;
			ctrl_sh <= utx_pkg::CTRL_RESET;
			guard_sh <= utx_pkg::GUARD_RESET;
			quiet <= 3'h7;
		end else begin
			if (hready_i)
				wp_q <= acc && hwrite_i;
			if (acc)
				wa_q <= haddr_i[7:0];
			if (quiet != 3'h7)
				quiet <= quiet + 3'h1;
			if (wp_q && hready_i) begin
				quiet <= 3'h0;
				if (wa_q == utx_pkg::OFS_CTRL)
					ctrl_sh <= hwdata_i;
				if (wa_q == utx_pkg::OFS_GUARD)
					guard_sh <= hwdata_i;
			end
		end
	end
	// Window after a sent packet or a control write
	always_ff @(posedge clk_i) begin
		if (rst_i)
			tog_win <= 3'h4;
		else if (tx_done_i || (wp_q && hready_i && wa_q == utx_pkg::OFS_CTRL))
			tog_win <= 3'h4;
		else if (tog_win != 3'h0)
			tog_win <= tog_win - 3'h1;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_host_no_iso: assert property (
		host_mode_i && $past(host_mode_i) |-> !iso_mode_o)
		else $error("timed mode shown in host role");
	a_dir_follows: assert property (
		quiet >= 3'h4 |-> dir_tx_o == ctrl_sh[29])
		else $error("direction output differs from written bit");
	a_dma_gated: assert property (
		quiet >= 3'h4 && !ctrl_sh[28] |-> !dma_req_o)
		else $error("request while requests disabled");
	a_phy_rst_held: assert property (
		quiet >= 3'h4 |-> phy_rst_o == guard_sh[25])
		else $error("phy domain reset differs from written bit");
	a_bus_rst_held: assert property (
		quiet >= 3'h4 |-> bus_rst_o == guard_sh[24])
		else $error("bus domain reset differs from written bit");
	a_toggle_cause: assert property (
		$changed(data_toggle_o) |-> tog_win != 3'h0)
		else $error("toggle moved without cause");
	a_link_hold: assert property (
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("stream word dropped or changed under stall");
	a_wait_bound: assert property (
		$fell(hreadyout_o) |-> ##[1:64] hreadyout_o)
		else $error("wait state too long");
	a_resp_okay: assert property (
		!hresp_o)
		else $error("error response on the register bus");
	c_stall: cover property (tx_valid_o && !tx_ready_i);
	c_dma: cover property ($rose(dma_req_o));
	c_phy_rst: cover property ($rose(phy_rst_o));
endmodule
bind utx_ep_ctrl utx_ep_ctrl_sva chk (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
	.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
	.hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.host_mode_i(host_mode_i),
	.tx_done_i(tx_done_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
	.tx_ready_i(tx_ready_i), .data_toggle_o(data_toggle_o), .iso_mode_o(iso_mode_o),
	.dir_tx_o(dir_tx_o), .dma_req_o(dma_req_o), .phy_rst_o(phy_rst_o),
	.bus_rst_o(bus_rst_o));
`default_nettype wire

// ### utx_link_model.sv
// Link-side partner: takes packet words off the endpoint's stream.
// Assumes the bench raises stall_i to model a busy link.
`default_nettype none
module utx_link_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic stall_i,
	input wire logic tx_valid_i,
	input wire logic [31:0] tx_data_i,
	output logic tx_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] rx_q[$]; // Words taken, oldest first
	// Ready moves only at an edge, so a stall never splits a handshake
	always_ff @(posedge clk_i)
		tx_ready_o <= !rst_i && !stall_i;
	// A word is taken where valid and ready meet at an edge
	always @(posedge clk_i)
		if (!rst_i && tx_valid_i === 1'b1 && tx_ready_o)
			rx_q.push_back(tx_data_i);
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the transmit endpoint controller.
// Assumes the bound checker and the link partner model beside the design.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FRM = 200; // Shortened frame, clocks
	localparam int UFRM = 50; // Shortened microframe, clocks
	localparam logic [7:0] A_CT = utx_pkg::OFS_CTRL;
	localparam logic [7:0] A_GD = utx_pkg::OFS_GUARD;
	localparam logic [7:0] A_FF = utx_pkg::OFS_FIFO;
	localparam logic [7:0] A_ST = utx_pkg::OFS_STAT;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic host = 1'b0;
	logic [1:0] speed = utx_pkg::SPD_FULL;
	logic sof = 1'b0;
	logic done = 1'b0;
	logic stall = 1'b0;
	logic [31:0] hrdata, txd;
	logic hready, txv, txr, pkt, tog, iso, dir, dma, gblk, prst, brst;
	logic [31:0] exp_q[$]; // Words expected on the link, in order
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	utx_ep_ctrl #(.FRAME_CYCLES(FRM), .UFRAME_CYCLES(UFRM)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .host_mode_i(host),
		.speed_i(speed), .sof_i(sof), .tx_done_i(done), .tx_data_o(txd), .tx_valid_o(txv),
		.tx_ready_i(txr), .tx_packet_ready_o(pkt), .data_toggle_o(tog), .iso_mode_o(iso),
		.dir_tx_o(dir), .dma_req_o(dma), .guard_block_o(gblk), .phy_rst_o(prst),
		.bus_rst_o(brst));
	utx_link_model link (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .tx_valid_i(txv),
		.tx_data_i(txd), .tx_ready_o(txr));
	initial begin
		forever #10 clk_i = !clk_i;
	end
	// Hang guard: the whole run needs under a thousand clocks
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask
	// One single AHB-Lite transfer; the slave sets the pace
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		do @(posedge clk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_i); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0000_0000, q);
		chk_word(q, exp);
	endtask
	task automatic push(input logic [31:0] d);
		exp_q.push_back(d);
		wr(A_FF, d);
	endtask
	// One-clock pulse on start of frame or on packet sent
	task automatic pulse(input logic is_sof);
		if (is_sof)
			sof <= 1'b1;
		else
			done <= 1'b1;
		step(1);
		sof <= 1'b0;
		done <= 1'b0;
		step(3);
	endtask
	function automatic logic [31:0] st(input logic v, input logic f, input logic b,
		input logic [12:0] n);
		return {12'h000, v, f, b, n, 4'h0};
	endfunction
	initial begin
		step(20);
		rst_i <= 1'b0;
		rd(A_CT, 32'h0000_0000);
		// 121.6/1.067 = 114, 63.46/0.5333 = 119, 17.07/0.1333 = 128
		rd(A_GD, 32'h0072_7780);
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10, 32'h0000_0000);
		rd(A_FF, 32'h0000_0000);
		$display("test reset done");
		host <= 1'b1;
		wr(A_CT, 32'h4200_0000);
		rd(A_CT, 32'h0200_0000);
		wr(A_CT, 32'h0300_0000);
		rd(A_CT, 32'h0300_0000);
		wr(A_CT, 32'h0100_0000);
		wr(A_CT, 32'h0000_0000);
		rd(A_CT, 32'h0100_0000);
		host <= 1'b0;
		wr(A_CT, 32'h6000_0000);
		rd(A_CT, 32'h6100_0000);
		chk_bit(iso, 1'b1);
		chk_bit(dir, 1'b1);
		host <= 1'b1;
		step(2);
		chk_bit(iso, 1'b0);
		rd(A_CT, 32'h2100_0000);
		host <= 1'b0;
		wr(A_CT, 32'h0800_0000);
		step(3);
		rd(A_CT, 32'h0000_0000);
		pulse(1'b0);
		chk_bit(tog, 1'b1);
		$display("test roles done");
		wr(A_CT, 32'h8000_0008);
		push(32'hA5A5_0001);
		step(3);
		chk_bit(pkt, 1'b0);
		push(32'hA5A5_0002);
		step(3);
		chk_bit(pkt, 1'b1);
		rd(A_ST, st(1'b0, 1'b0, 1'b1, 13'h8));
		pulse(1'b0);
		chk_bit(pkt, 1'b0);
		push(32'h5A5A_0003);
		step(3);
		chk_bit(pkt, 1'b0);
		wr(A_CT, 32'h8001_0008);
		step(3);
		chk_bit(pkt, 1'b1);
		pulse(1'b0);
		wr(A_CT, 32'h0000_0008);
		push(32'h0F0F_0004);
		push(32'h0F0F_0005);
		step(3);
		chk_bit(pkt, 1'b0);
		wr(A_CT, 32'h0001_0008);
		step(3);
		chk_bit(pkt, 1'b1);
		pulse(1'b0);
		$display("test packet ready done");
		push(32'h1111_0006);
		push(32'h1111_0007);
		wr(A_CT, 32'h1000_0008);
		step(3);
		chk_bit(dma, 1'b1);
		wr(A_CT, 32'h1400_0008);
		step(3);
		chk_bit(dma, 1'b0);
		pulse(1'b0);
		chk_bit(dma, 1'b1);
		wr(A_CT, 32'h0400_0008);
		step(3);
		chk_bit(dma, 1'b0);
		wr(A_CT, 32'h0000_0008);
		$display("test dma done");
		stall <= 1'b1;
		push(32'h2222_0008);
		push(32'h2222_0009);
		rd(A_ST, st(1'b1, 1'b1, 1'b1, 13'h8));
		fork
			begin
				step(12);
				stall <= 1'b0;
			end
		join_none
		push(32'h2222_000A);
		step(10);
		rd(A_ST, st(1'b0, 1'b0, 1'b1, 13'hC));
		pulse(1'b0);
		$display("test buffer done");
		wr(A_GD, 32'h0002_0405);
		rd(A_GD, 32'h0002_0405);
		for (int i = 0; i < 3; i++) begin
			speed <= 2'(i);
			pulse(1'b1);
			step(i == 2 ? 6 : 56);
			chk_bit(gblk, 1'b0);
			step(i == 2 ? 15 : 70);
			chk_bit(gblk, 1'b1);
		end
		wr(A_GD, 32'h0002_0005);
		speed <= utx_pkg::SPD_FULL;
		pulse(1'b1);
		step(190);
		chk_bit(gblk, 1'b0);
		wr(A_GD, 32'h0302_0405);
		step(20);
		chk_bit(prst, 1'b1);
		chk_bit(brst, 1'b1);
		rd(A_GD, 32'h0302_0405);
		wr(A_GD, 32'h0002_0405);
		step(3);
		chk_bit(prst, 1'b0);
		chk_bit(brst, 1'b0);
		$display("test guard done");
		rst_i <= 1'b1;
		step(3);
		rst_i <= 1'b0;
		rd(A_GD, 32'h0072_7780);
		chk_word(32'(link.rx_q.size()), 32'(exp_q.size()));
		foreach (exp_q[i])
			chk_word(link.rx_q[i], exp_q[i]);
		$display("test stream done");
		report_and_stop();
	end
endmodule
`default_nettype wire
